// ### src/cpg_map.svh
/*
  register offsets, field positions and reset values of the cascaded
  pulse generator; assumes a 32-bit apb slave with byte addresses.
*/
`ifndef CPG_MAP_SVH
`define CPG_MAP_SVH

// byte offsets, one aligned word each
`define CPG_LOWER_CTRL_OFS  8'h00
`define CPG_UPPER_CTRL_OFS  8'h04
`define CPG_DUTY_LOW_OFS    8'h08
`define CPG_DUTY_HIGH_OFS   8'h0c
`define CPG_PERIOD_LOW_OFS  8'h10
`define CPG_PERIOD_HIGH_OFS 8'h14
`define CPG_STATUS_OFS      8'h18
`define CPG_POWER_OFS       8'h1c

// lower control: count source select in [2:0], 3'h7 = count pin
`define CPG_SRC_LSB  0
`define CPG_SRC_EXT  3'h7
// upper control fields
`define CPG_MODE_LSB 0
`define CPG_RUN_BIT  3
`define CPG_FFI_BIT  7
// power register fields
`define CPG_SLOW_BIT 0
`define CPG_PSEL_BIT 1
// status: counter in [15:0], output flop in bit 16
`define CPG_STAT_FF_BIT 16

// reset values
`define CPG_CTRL_RST 8'h00
`define CPG_CMP_RST  16'hffff

`endif

// ### src/cpg_pkg.sv
/*
  types of the cascaded pulse generator; no assumptions.
*/
package cpg_pkg;
  // operating mode held in the upper control register
  typedef enum logic [1:0] {
    CPG_MODE_PWM,
    CPG_MODE_PPG,
    CPG_MODE_WARM,
    CPG_MODE_OFF
  } cpg_mode_t;
endpackage

// ### src/cpg_timer.sv
/*
  cascaded 16-bit pulse generator: pwm, programmable pulse and warm-up
  counter modes behind an apb slave.
  assumes pclk is the fast clock fc; the slow clock fs is a tick made
  by dividing pclk; the count pin is asynchronous.
*/
//
// Behaviour
// - two bytes chain into one 16-bit up-counter
// - pwm duty match inverts flop, keeps counting
// - pwm overflow inverts flop, clears, raises irq
// - flop loads initial bit; reset clears it
// - pulse pins show inverse of flop in own mode
// - pwm duty buffered until irq, immediate stopped
// - pwm duty read returns active stage
// - stop holds pin; initial bit written separately
// - count source set depends on power mode
// - ppg duty inverts, period inverts and clears
// - ppg compare registers act immediately
// - warm-up mode times clock switch stabilisation
// - warm-up compares only period upper byte
// - counting starts only once run bit set
`timescale 1ns/10ps
`include "cpg_map.svh"
`default_nettype none

module cpg_timer
  import cpg_pkg::*;
#(
  parameter int FS_DIV = 3815  // pclk cycles per fs tick
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_pin,
  output logic             pwm_pulse_pin,
  output logic             prog_pulse_pin,
  output logic             cascade_timer_irq
);

  // software registers
  logic [7:0]  lower_ctrl_q;     // count source select
  logic [7:0]  upper_ctrl_q;     // mode, run, initial flop level
  logic [15:0] duty_hold_q;      // written duty value
  logic [15:0] duty_act_q;       // duty value used by pwm compare
  logic [15:0] period_q;         // period compare value
  logic [1:0]  power_q;          // slow mode and prescaler select
  // counting state
  logic [15:0] cnt_q;            // cascaded up-counter
  logic        flop_q;           // output toggle flop
  logic        irq_q;            // interrupt pulse
  logic        pwm_pin_q;
  logic        ppg_pin_q;
  logic [10:0] pre_q;            // fast prescaler
  logic [11:0] fs_div_q;         // slow clock divider
  logic [2:0]  fs_pre_q;         // fs/2^3 divider
  logic [2:0]  ext_sync_q;       // count pin synchroniser
  logic        ext_lvl_q;        // filtered pin level
  logic        ext_fall;
  logic        fs_tick;
  logic        tick;
  // apb response
  logic [31:0] rdata_q;
  logic        ready_q;
  logic        err_q;

  cpg_mode_t   mode;
  logic        run;
  logic        wr;
  logic        mapped;
  logic [15:0] nxt;
  logic [15:0] duty_cmp;
  logic [15:0] duty_rd;
  logic        flop_d;

  assign mode = cpg_mode_t'(upper_ctrl_q[`CPG_MODE_LSB +: 2]);
  assign run  = upper_ctrl_q[`CPG_RUN_BIT];
  assign nxt  = cnt_q + 16'h0001;
  // a write lands on the access edge only
  assign wr   = psel & penable & pwrite & ready_q;

  // fast prescaler and slow clock tick, both free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q    <= 11'h000;
      fs_div_q <= 12'h000;
      fs_pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 11'h001;
      if (fs_tick) begin
        fs_div_q <= 12'h000;
        fs_pre_q <= fs_pre_q + 3'h1;
      end else begin
        fs_div_q <= fs_div_q + 12'h001;
      end
    end
  end
  assign fs_tick = (fs_div_q == 12'(FS_DIV - 1));

  // count pin: three flops, a level counts once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_count_pin};
      if (ext_sync_q[2] == ext_sync_q[1]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
    end
  end
  // pin rate bound
  // the pin is only sampled; pulses shorter than the filter are lost
  assign ext_fall = ext_lvl_q & ~ext_sync_q[2] & ~ext_sync_q[1];

  // count source choice
  // slow mode allows only fs/2^3, fs and the count pin; other codes stall the counter
  always_comb begin
    tick = 1'b0;
    unique case (lower_ctrl_q[`CPG_SRC_LSB +: 3])
      3'h0: begin
        if (power_q[`CPG_SLOW_BIT] || power_q[`CPG_PSEL_BIT]) begin
          tick = fs_tick & (fs_pre_q == 3'h7);
        end else begin
          tick = &pre_q[10:0];
        end
      end
      3'h1: tick = ~power_q[`CPG_SLOW_BIT] & (&pre_q[6:0]);
      3'h2: tick = ~power_q[`CPG_SLOW_BIT] & (&pre_q[4:0]);
      3'h3: tick = ~power_q[`CPG_SLOW_BIT] & (&pre_q[2:0]);
      3'h4: tick = fs_tick;
      3'h5: tick = ~power_q[`CPG_SLOW_BIT] & pre_q[0];
      3'h6: tick = ~power_q[`CPG_SLOW_BIT];
      3'h7: tick = ext_fall;
    endcase
  end

  // ppg compares the written value directly
  assign duty_cmp = (mode == CPG_MODE_PWM) ? duty_act_q : duty_hold_q;
  // pwm read shows the active stage
  assign duty_rd  = (mode == CPG_MODE_PWM) ? duty_act_q : duty_hold_q;

  // control and compare registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_ctrl_q <= `CPG_CTRL_RST;
      upper_ctrl_q <= `CPG_CTRL_RST;
      duty_hold_q  <= `CPG_CMP_RST;
      period_q     <= `CPG_CMP_RST;
      power_q      <= 2'h0;
    end else if (wr) begin
      unique case (paddr)
        `CPG_LOWER_CTRL_OFS:  lower_ctrl_q      <= pwdata[7:0];
        `CPG_UPPER_CTRL_OFS:  upper_ctrl_q      <= pwdata[7:0];
        `CPG_DUTY_LOW_OFS:    duty_hold_q[7:0]  <= pwdata[7:0];
        `CPG_DUTY_HIGH_OFS:   duty_hold_q[15:8] <= pwdata[7:0];
        `CPG_PERIOD_LOW_OFS:  period_q[7:0]     <= pwdata[7:0];
        `CPG_PERIOD_HIGH_OFS: period_q[15:8]    <= pwdata[7:0];
        `CPG_POWER_OFS:       power_q           <= pwdata[1:0];
        default: ;  // status and unmapped words take no write
      endcase
    end
  end

  // duty transfer stage
  // while stopped the stage follows each byte at once; when running
  // it takes the held value only with the interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_act_q <= `CPG_CMP_RST;
    end else if (!run) begin
      duty_act_q <= duty_hold_q;
    end else if (irq_q && mode == CPG_MODE_PWM) begin
      duty_act_q <= duty_hold_q;
    end
  end

  // flop next value: stop, initial load and compare matches
  always_comb begin
    flop_d = flop_q;
    if (!run) begin
      // stop holds the level
      // only a control write made while already stopped loads the flop
      // initial level load
      if (wr && paddr == `CPG_UPPER_CTRL_OFS && !pwdata[`CPG_RUN_BIT]) begin
        flop_d = pwdata[`CPG_FFI_BIT];
      end
    end else if (tick) begin
      unique case (mode)
        CPG_MODE_PWM: begin
          if (nxt == duty_cmp) begin
            flop_d = ~flop_d;
          end
          if (cnt_q == 16'hffff) begin
            flop_d = ~flop_d;
          end
        end
        CPG_MODE_PPG: begin
          // period match wins over duty match
          if (nxt == period_q || nxt == duty_cmp) begin
            flop_d = ~flop_q;
          end
        end
        default: ;  // warm-up and off leave the flop alone
      endcase
    end
  end

  // counts only while run is set; a stop also clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      if (!run) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        cnt_q <= nxt;
        unique case (mode)
          CPG_MODE_PWM: if (cnt_q == 16'hffff) begin
            irq_q <= 1'b1;
          end
          CPG_MODE_PPG: if (nxt == period_q) begin
            cnt_q <= 16'h0000;
            irq_q <= 1'b1;
          end
          CPG_MODE_WARM: if (nxt[15:8] == period_q[15:8]) begin
            cnt_q <= 16'h0000;
            irq_q <= 1'b1;
          end
          default: ;  // off: count without events
        endcase
      end
    end
  end

  // flop and pins; pins idle high outside their own mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flop_q    <= 1'b0;
      pwm_pin_q <= 1'b1;
      ppg_pin_q <= 1'b1;
    end else begin
      flop_q    <= flop_d;
      pwm_pin_q <= (mode == CPG_MODE_PWM) ? ~flop_d : 1'b1;
      ppg_pin_q <= (mode == CPG_MODE_PPG) ? ~flop_d : 1'b1;
    end
  end

  // apb: read data staged in setup, answered in one access cycle
  assign mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      ready_q <= psel & ~penable;
      err_q   <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `CPG_LOWER_CTRL_OFS:  rdata_q <= {24'h0, lower_ctrl_q};
          `CPG_UPPER_CTRL_OFS:  rdata_q <= {24'h0, upper_ctrl_q};
          `CPG_DUTY_LOW_OFS:    rdata_q <= {24'h0, duty_rd[7:0]};
          `CPG_DUTY_HIGH_OFS:   rdata_q <= {24'h0, duty_rd[15:8]};
          `CPG_PERIOD_LOW_OFS:  rdata_q <= {24'h0, period_q[7:0]};
          `CPG_PERIOD_HIGH_OFS: rdata_q <= {24'h0, period_q[15:8]};
          `CPG_STATUS_OFS:      rdata_q <= {15'h0, flop_q, cnt_q};
          `CPG_POWER_OFS:       rdata_q <= {30'h0, power_q};
          default:              rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata            = rdata_q;
  assign pready            = ready_q;
  assign pslverr           = err_q;
  assign pwm_pulse_pin     = pwm_pin_q;
  assign prog_pulse_pin    = ppg_pin_q;
  assign cascade_timer_irq = irq_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence pwm_wrap_s;
    run && mode == CPG_MODE_PWM && tick && cnt_q == 16'hffff;
  endsequence

  irq_clears_a: assert property (irq_q |-> cnt_q == 16'h0000)
    else $error("irq without counter clear");
  pwm_wrap_a: assert property (pwm_wrap_s |=> irq_q && cnt_q == 16'h0000)
    else $error("pwm overflow missed");
  pwm_match_a: assert property (run && mode == CPG_MODE_PWM && tick
      && cnt_q != 16'hffff && nxt == duty_act_q |=> flop_q != $past(flop_q))
    else $error("pwm duty match did not toggle");
  ppg_period_a: assert property (run && mode == CPG_MODE_PPG && tick
      && nxt == period_q |=> irq_q && flop_q != $past(flop_q))
    else $error("ppg period match missed");
  warm_upper_a: assert property (run && mode == CPG_MODE_WARM && tick
      && nxt[15:8] == period_q[15:8] |=> irq_q)
    else $error("warm-up upper byte match missed");
  pin_inverse_a: assert property (mode == CPG_MODE_PWM ##1
      mode == CPG_MODE_PWM |-> pwm_pin_q == ~flop_q)
    else $error("pwm pin not inverse of flop");
  ppg_pin_inverse_a: assert property (mode == CPG_MODE_PPG ##1
      mode == CPG_MODE_PPG |-> ppg_pin_q == ~flop_q)
    else $error("ppg pin not inverse of flop");
  // the last counting edge may still toggle; from then on only a control write may
  stop_hold_a: assert property (!run && !(wr && paddr == `CPG_UPPER_CTRL_OFS)
      |=> flop_q == $past(flop_q))
    else $error("flop changed on stop");
  duty_xfer_a: assert property (irq_q && mode == CPG_MODE_PWM && run
      |=> duty_act_q == $past(duty_hold_q))
    else $error("duty stage not loaded at irq");
  idle_stopped_a: assert property (!run [*2] |-> cnt_q == 16'h0000 && !irq_q)
    else $error("counter moved while stopped");

endmodule // cpg_timer

`default_nettype wire

// ### test/cpg_timer_tb.sv
/*
  self-checking bench for cpg_timer: apb master tasks and one task per scenario.
  assumes cpg_pkg and cpg_map.svh are compiled first; pclk doubles as fc.
*/
`timescale 1ns/10ps
`include "cpg_map.svh"
`default_nettype none

module testbench;
  import cpg_pkg::*;
  logic        pclk = 1'b0;     // 125 MHz clock
  logic        presetn = 1'b0;  // active low reset
  logic        psel = 1'b0;     // apb select
  logic        penable = 1'b0;  // apb access phase
  logic        pwrite = 1'b0;   // apb direction
  logic [7:0]  paddr = 8'h00;   // apb byte address
  logic [31:0] pwdata = 32'h0;  // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb answer
  logic        pslverr;         // apb error
  logic        pwm_pin;         // pwm output, inverted flop
  logic        ppg_pin;         // programmable pulse output
  logic        irq;             // cascade irq pulse
  int          bad_count = 0;   // mismatches
  int          check_count = 0; // comparisons
  int          cycles = 0;      // watchdog count
  logic        ext_pin = 1'b1;  // count pin, idles high
  localparam int FS_SIM = 4;    // pclk cycles per fs tick in simulation

  // short fs divider keeps the slow sources quick in simulation
  cpg_timer #(.FS_DIV(FS_SIM)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
    .pwm_pulse_pin(pwm_pin), .prog_pulse_pin(ppg_pin), .cascade_timer_irq(irq)
  );

  // clock: 8 ns period
  always #4 pclk = ~pclk;

  // watchdog: the pwm frame alone needs about 66k cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles >= 80000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; an idle cycle first so psel never changes twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit here: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'd1, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  // waits for one irq pulse; counts cycles and low samples of the chosen pin
  task automatic wait_irq(input logic use_ppg, output int lo, output int cyc);
    lo = 0;
    cyc = 0;
    do begin
      @(posedge pclk);
      #1;
      cyc++;
      if ((use_ppg ? ppg_pin : pwm_pin) === 1'b0) lo++;
    end while (irq !== 1'b1);
  endtask

  // reset state and an unmapped access
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk("pins idle", 32'h3, {30'h0, pwm_pin, ppg_pin});
    chk("irq idle", 32'h0, {31'h0, irq});
    rd("duty low reset", `CPG_DUTY_LOW_OFS, 32'hff);
    rd("status reset", `CPG_STATUS_OFS, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask

  // programmable pulse: duty 3, period 9, then stop and hold
  task automatic t_ppg();
    int lo;
    int cyc;
    logic held;
    wr(`CPG_LOWER_CTRL_OFS, 8'h06);
    wr(`CPG_DUTY_LOW_OFS, 8'h03);
    wr(`CPG_DUTY_HIGH_OFS, 8'h00);
    wr(`CPG_PERIOD_LOW_OFS, 8'h09);
    wr(`CPG_PERIOD_HIGH_OFS, 8'h00);
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    rd("counter before run", `CPG_STATUS_OFS, 32'h0);
    wr(`CPG_UPPER_CTRL_OFS, 8'h09);
    wait_irq(1'b1, lo, cyc);
    wait_irq(1'b1, lo, cyc);
    chk("ppg period", 32'd9, cyc);
    chk("ppg low width", 32'd6, lo);
    chk("pwm pin unused", 32'h1, {31'h0, pwm_pin});
    // new period only while stopped; flop reloaded by a separate write
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    wr(`CPG_PERIOD_LOW_OFS, 8'h05);
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    wr(`CPG_UPPER_CTRL_OFS, 8'h09);
    wait_irq(1'b1, lo, cyc);
    wait_irq(1'b1, lo, cyc);
    chk("ppg new period", 32'd5, cyc);
    chk("ppg new low width", 32'd2, lo);
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    // the stopping edge may still toggle, so take the level just after it
    #1;
    held = ppg_pin;
    repeat (12) @(posedge pclk);
    #1;
    chk("pin held on stop", {31'h0, held}, {31'h0, ppg_pin});
    wr(`CPG_UPPER_CTRL_OFS, 8'h81);
    rd("flop loaded", `CPG_STATUS_OFS, 32'h10000);
    chk("pin inverse", 32'h0, {31'h0, ppg_pin});
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
  endtask

  // pwm: duty ff00, rewrite to fe00 while running
  task automatic t_pwm();
    int lo;
    int cyc;
    wr(`CPG_UPPER_CTRL_OFS, 8'h00);
    wr(`CPG_DUTY_LOW_OFS, 8'h00);
    wr(`CPG_DUTY_HIGH_OFS, 8'hff);
    rd("duty stopped", `CPG_DUTY_HIGH_OFS, 32'hff);
    wr(`CPG_UPPER_CTRL_OFS, 8'h08);
    // rewritten long before the next irq, so the two never coincide
    wr(`CPG_DUTY_LOW_OFS, 8'h00);
    wr(`CPG_DUTY_HIGH_OFS, 8'hfe);
    rd("duty before irq", `CPG_DUTY_HIGH_OFS, 32'hff);
    wait_irq(1'b0, lo, cyc);
    chk("pwm low width", 32'd256, lo);
    chk("pin back at wrap", 32'h1, {31'h0, pwm_pin});
    @(posedge pclk);
    #1;
    chk("irq one cycle", 32'h0, {31'h0, irq});
    rd("duty after irq", `CPG_DUTY_HIGH_OFS, 32'hfe);
    wr(`CPG_UPPER_CTRL_OFS, 8'h00);
  endtask

  // count pin: ppg with duty 1, period 3, each level held four clocks
  task automatic t_ext();
    int lo;
    int cyc;
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    wr(`CPG_LOWER_CTRL_OFS, 8'h07);
    wr(`CPG_DUTY_LOW_OFS, 8'h01);
    wr(`CPG_DUTY_HIGH_OFS, 8'h00);
    wr(`CPG_PERIOD_LOW_OFS, 8'h03);
    wr(`CPG_PERIOD_HIGH_OFS, 8'h00);
    wr(`CPG_UPPER_CTRL_OFS, 8'h09);
    repeat (2) begin
      ext_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      ext_pin <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    // two falls: counter at 2, flop set by the duty match at 1
    rd("count pin events", `CPG_STATUS_OFS, 32'h10002);
    // third fall: three filter flops, then the counting edge
    ext_pin <= 1'b0;
    wait_irq(1'b1, lo, cyc);
    chk("count pin latency", 32'd4, cyc);
    @(posedge pclk);
    ext_pin <= 1'b1;
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
  endtask

  // one source: restart with period 3 and time a whole period
  task automatic src_run(input logic [7:0] src, input string what, input int exp);
    int lo;
    int cyc;
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    wr(`CPG_LOWER_CTRL_OFS, src);
    wr(`CPG_UPPER_CTRL_OFS, 8'h09);
    wait_irq(1'b1, lo, cyc);
    wait_irq(1'b1, lo, cyc);
    chk(what, exp, cyc);
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
  endtask

  // count sources in normal, prescaler-select and slow power settings
  task automatic t_src();
    logic [31:0] r;
    logic e;
    src_run(8'h04, "fs source period", 3 * FS_SIM);
    src_run(8'h03, "fc/8 source period", 3 * 8);
    wr(`CPG_POWER_OFS, 8'h02);
    src_run(8'h00, "select bit fs/8 period", 3 * 8 * FS_SIM);
    wr(`CPG_POWER_OFS, 8'h01);
    src_run(8'h00, "slow fs/8 period", 3 * 8 * FS_SIM);
    // fc is not allowed in slow mode: the counter must not move
    wr(`CPG_LOWER_CTRL_OFS, 8'h06);
    wr(`CPG_UPPER_CTRL_OFS, 8'h09);
    repeat (20) @(posedge pclk);
    apb(1'b0, `CPG_STATUS_OFS, 32'h0, r, e);
    chk("slow fc stalls", 32'h0, {16'h0, r[15:0]});
    wr(`CPG_UPPER_CTRL_OFS, 8'h01);
    wr(`CPG_POWER_OFS, 8'h00);
  endtask

  // warm-up: only the upper period byte counts, so 0205 gives 512
  task automatic t_warm();
    int lo;
    int cyc;
    wr(`CPG_UPPER_CTRL_OFS, 8'h02);
    wr(`CPG_PERIOD_LOW_OFS, 8'h05);
    wr(`CPG_PERIOD_HIGH_OFS, 8'h02);
    wr(`CPG_UPPER_CTRL_OFS, 8'h0a);
    wait_irq(1'b1, lo, cyc);
    wait_irq(1'b1, lo, cyc);
    chk("warm-up interval", 32'd512, cyc);
    chk("pins quiet", 32'h3, {30'h0, pwm_pin, ppg_pin});
    wr(`CPG_UPPER_CTRL_OFS, 8'h02);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ppg();
    t_warm();
    t_pwm();
    t_ext();
    t_src();
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
